// File: verilog/mdacr_pkg.sv
// Constants, register selectors and bus carrier of the DAC register bank
`default_nettype none
package mdacr_pkg;
  localparam int          DATA_W      = 16;
  localparam int          OFS_W       = 14;
  localparam int          NUM_CH      = 16;
  localparam int          GRP_SZ      = 8;
  localparam int          NUM_GRP     = 2;
  localparam int          CH_W        = 4;
  // Control register fields
  localparam int          CTL_OVERTEMP = 4;
  localparam int          CTL_PKT_ERR  = 3;
  localparam int          CTL_AB_SEL   = 2;
  localparam int          CTL_TSD_EN   = 1;
  localparam int          CTL_PWR_DOWN = 0;
  // Monitor register fields
  localparam int          MON_ENABLE   = 5;
  localparam int          MON_EXT      = 4;
  localparam int          MON_INPUT_1  = 0;
  // Pin register fields
  localparam int          AUX_DIR      = 1;
  localparam int          AUX_DATA     = 0;
  // Values after reset, then trim midscale, saturation and sign-flip constants
  localparam logic [15:0] INPUT_RST    = 16'h8000;
  localparam logic [15:0] GAIN_RST     = 16'hFFFF;
  localparam logic [15:0] OFFSET_RST   = 16'h8000;
  localparam logic [15:0] CAL_RST      = 16'h8000;
  localparam logic [13:0] GRP_OFS_RST  = 14'h2000;
  localparam logic [18:0] CODE_MID     = 19'h08000;
  localparam logic [15:0] CODE_MAX     = 16'hFFFF;
  localparam logic [15:0] SIGN_FLIP    = 16'h8000;

  // Register selector carried on the command port
  typedef enum logic [3:0] {
    SEL_INPUT     = 4'h0,  // Input A or B, chosen by the control A/B bit
    SEL_INPUT_A   = 4'h1,  // Read of input A regardless of the A/B bit
    SEL_INPUT_B   = 4'h2,
    SEL_GAIN      = 4'h3,
    SEL_OFFSET    = 4'h4,
    SEL_GRP_OFS   = 4'h5,  // Channel field bit 0 picks the group
    SEL_CONTROL   = 4'h6,
    SEL_MONITOR   = 4'h7,
    SEL_AUX_PIN   = 4'h8,
    SEL_AB_SELECT = 4'h9   // Channel field bit 0 picks the group
  } mdacr_sel_t;

  typedef struct packed {
    logic             wr;
    logic             rd;
    mdacr_sel_t       sel;
    logic [CH_W-1:0]  chan;
    logic [15:0]      data;
  } mdacr_req_t;
endpackage : mdacr_pkg
`default_nettype wire

// File: verilog/mdacr_bank.sv
// Register and control logic of the multichannel DAC
`default_nettype none
// Notes on behaviour
// - Aux pin works as input or output, read or driven through the registers.
// - Pin register bit 1 sets direction: 0 input, 1 output.
// - Pin bit 0 samples the pin as input, drives it as output.
// - Coding input low means offset binary, high means two's complement.
// - Every channel has input registers A and B, 16 bits wide.
// - Every channel has gain trim and offset trim registers, 16 bits wide.
// - Calibrated A and B registers hold trimmed data; host cannot access them.
// - Final converter register loads only from calibrated A or B, never host.
// - Two 14-bit group offset level registers, one per channel group.
// - Control bit 4 reads 1 while die temperature exceeds 130 degrees.
// - Control bit 3 sets on packet error, clears when control is read.
// - Control bit 2 globally steers data writes to input A or B.
// - Control bit 1 enables automatic thermal shutdown.
// - Control bit 0 puts the device in soft power-down.
// - Monitor bit 5 switches the monitor output on or off.
// - Monitor bit 4 low: bits 3 to 0 pick channel 0 to 15.
// - Monitor bit 4 high: bit 0 picks external monitor input zero or one.
// - Writes to input, gain or offset recompute calibrated A or B per the control A/B bit.
// - Per-group 8-bit select register picks calibrated A or B per channel.
// - Load input low updates all final registers from their selected source.
module mdacr_bank
  import mdacr_pkg::*;
(
  // Clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             rst,
  // Register command port
  input  wire mdacr_req_t                       req,
  output var  logic [15:0]                      rd_data,
  output var  logic                             rd_valid,
  // Device pins and conditions
  input  wire logic                             code_format_select,
  input  wire logic                             load_outputs_n,
  input  wire logic                             over_temp,
  input  wire logic                             pec_fail,
  input  wire logic                             aux_pin_i,
  output var  logic                             aux_pin_o,
  output var  logic                             aux_pin_oe,
  // Converter and analog control
  output var  logic [NUM_CH-1:0][DATA_W-1:0]    dac_code,
  output var  logic [NUM_GRP-1:0][OFS_W-1:0]    group_offset_level,
  output var  logic                             power_down,
  output var  logic                             thermal_shutdown,
  output var  logic                             monitor_on,
  output var  logic                             monitor_use_ext,
  output var  logic [CH_W-1:0]                  monitor_channel,
  output var  logic                             monitor_input_one
);

  logic [NUM_CH-1:0][DATA_W-1:0]  input_a_ff, nxt_input_a;
  logic [NUM_CH-1:0][DATA_W-1:0]  input_b_ff, nxt_input_b;
  logic [NUM_CH-1:0][DATA_W-1:0]  gain_ff, nxt_gain;
  logic [NUM_CH-1:0][DATA_W-1:0]  offset_ff, nxt_offset;
  logic [NUM_CH-1:0][DATA_W-1:0]  cal_a_ff, nxt_cal_a;
  logic [NUM_CH-1:0][DATA_W-1:0]  cal_b_ff, nxt_cal_b;
  logic [NUM_CH-1:0][DATA_W-1:0]  dac_ff;
  logic [NUM_GRP-1:0][OFS_W-1:0]  grp_ofs_ff, nxt_grp_ofs;
  logic [NUM_GRP-1:0][GRP_SZ-1:0] ab_select_ff, nxt_ab_select;
  logic                           ab_ff, nxt_ab;
  logic                           tsd_en_ff, nxt_tsd_en;
  logic                           pd_ff, nxt_pd;
  logic                           pkt_err_ff, nxt_pkt_err;
  logic                           overtemp_ff, nxt_overtemp;
  logic                           tsd_ff, nxt_tsd;
  logic [5:0]                     monitor_ff, nxt_monitor;
  logic                           aux_dir_ff, nxt_aux_dir;
  logic                           aux_data_ff, nxt_aux_data;
  logic [15:0]                    rd_data_ff, nxt_rd_data;
  logic                           rd_valid_ff, nxt_rd_valid;
  // One pending job for the shared multiply-add
  logic                           calc_ff, nxt_calc;
  logic                           calc_b_ff, nxt_calc_b;
  logic [CH_W-1:0]                calc_ch_ff, nxt_calc_ch;

  logic [DATA_W-1:0]              calc_x;
  logic [32:0]                    calc_prod;
  logic [18:0]                    calc_sum;
  logic [DATA_W-1:0]              calc_res;
  logic                           wr_trim;

  // Shared multiplier: one channel per cycle, fed from the job register
  always_comb begin
    calc_x    = calc_b_ff ? input_b_ff[calc_ch_ff] : input_a_ff[calc_ch_ff];
    // Two's complement codes are moved to offset binary before trimming
    if (code_format_select) begin
      calc_x = calc_x ^ SIGN_FLIP;
    end
    calc_prod = 33'(calc_x) * 33'({1'b0, gain_ff[calc_ch_ff]} + 17'h00001);
    calc_sum  = {2'b00, calc_prod[32:16]} + {3'b000, offset_ff[calc_ch_ff]} - CODE_MID;
    // Results outside the code range saturate instead of wrapping
    if (calc_sum[18]) begin
      calc_res = '0;
    end else if (calc_sum[17:16] != 2'b00) begin
      calc_res = CODE_MAX;
    end else begin
      calc_res = calc_sum[15:0];
    end
  end

  always_comb begin
    nxt_input_a   = input_a_ff;
    nxt_input_b   = input_b_ff;
    nxt_gain      = gain_ff;
    nxt_offset    = offset_ff;
    nxt_cal_a     = cal_a_ff;
    nxt_cal_b     = cal_b_ff;
    nxt_grp_ofs   = grp_ofs_ff;
    nxt_ab_select = ab_select_ff;
    nxt_ab        = ab_ff;
    nxt_tsd_en    = tsd_en_ff;
    nxt_pd        = pd_ff;
    nxt_monitor   = monitor_ff;
    nxt_aux_dir   = aux_dir_ff;
    nxt_aux_data  = aux_data_ff;
    nxt_overtemp  = over_temp;
    nxt_tsd       = tsd_en_ff & overtemp_ff;
    nxt_pkt_err   = pkt_err_ff;
    wr_trim       = 1'b0;

    // Calibrated registers are written only by the multiply-add
    if (calc_ff) begin
      if (calc_b_ff) begin
        nxt_cal_b[calc_ch_ff] = calc_res;
      end else begin
        nxt_cal_a[calc_ch_ff] = calc_res;
      end
    end

    // Sampled before the write so a write that turns the pin to output drives its written bit 0
    if (!aux_dir_ff) begin
      nxt_aux_data = aux_pin_i;
    end

    if (req.wr) begin
      case (req.sel)
        SEL_INPUT: begin
          if (ab_ff) begin
            nxt_input_b[req.chan] = req.data;
          end else begin
            nxt_input_a[req.chan] = req.data;
          end
          wr_trim = 1'b1;
        end
        SEL_GAIN: begin
          nxt_gain[req.chan] = req.data;
          wr_trim            = 1'b1;
        end
        SEL_OFFSET: begin
          nxt_offset[req.chan] = req.data;
          wr_trim              = 1'b1;
        end
        SEL_GRP_OFS: begin
          nxt_grp_ofs[req.chan[0]] = req.data[OFS_W-1:0];
        end
        SEL_CONTROL: begin
          // Status bits 4 and 3 are not writable
          nxt_ab     = req.data[CTL_AB_SEL];
          nxt_tsd_en = req.data[CTL_TSD_EN];
          nxt_pd     = req.data[CTL_PWR_DOWN];
        end
        SEL_MONITOR: begin
          nxt_monitor = req.data[5:0];
        end
        SEL_AUX_PIN: begin
          nxt_aux_dir = req.data[AUX_DIR];
          if (req.data[AUX_DIR]) begin
            nxt_aux_data = req.data[AUX_DATA];
          end
        end
        SEL_AB_SELECT: begin
          nxt_ab_select[req.chan[0]] = req.data[GRP_SZ-1:0];
        end
        default: begin
        end
      endcase
    end

    // A new error wins over the clearing read in the same cycle
    if (req.rd && req.sel == SEL_CONTROL) begin
      nxt_pkt_err = 1'b0;
    end
    if (pec_fail) begin
      nxt_pkt_err = 1'b1;
    end
  end

  // The job uses the A/B bit as it stood when the write was taken
  always_comb begin
    nxt_calc    = wr_trim;
    nxt_calc_b  = ab_ff;
    nxt_calc_ch = req.chan;
  end

  always_comb begin
    nxt_rd_valid = req.rd;
    nxt_rd_data  = '0;
    if (req.rd) begin
      case (req.sel)
        SEL_INPUT:     nxt_rd_data = ab_ff ? input_b_ff[req.chan] : input_a_ff[req.chan];
        SEL_INPUT_A:   nxt_rd_data = input_a_ff[req.chan];
        SEL_INPUT_B:   nxt_rd_data = input_b_ff[req.chan];
        SEL_GAIN:      nxt_rd_data = gain_ff[req.chan];
        SEL_OFFSET:    nxt_rd_data = offset_ff[req.chan];
        SEL_GRP_OFS:   nxt_rd_data = {2'b00, grp_ofs_ff[req.chan[0]]};
        SEL_CONTROL:   nxt_rd_data = {11'h000, overtemp_ff, pkt_err_ff, ab_ff, tsd_en_ff, pd_ff};
        SEL_MONITOR:   nxt_rd_data = {10'h000, monitor_ff};
        SEL_AUX_PIN:   nxt_rd_data = {14'h0000, aux_dir_ff, aux_data_ff};
        SEL_AB_SELECT: nxt_rd_data = {8'h00, ab_select_ff[req.chan[0]]};
        default:       nxt_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      input_a_ff   <= {NUM_CH{INPUT_RST}};
      input_b_ff   <= {NUM_CH{INPUT_RST}};
      gain_ff      <= {NUM_CH{GAIN_RST}};
      offset_ff    <= {NUM_CH{OFFSET_RST}};
      cal_a_ff     <= {NUM_CH{CAL_RST}};
      cal_b_ff     <= {NUM_CH{CAL_RST}};
      grp_ofs_ff   <= {NUM_GRP{GRP_OFS_RST}};
      ab_select_ff <= '0;
      ab_ff        <= 1'b0;
      tsd_en_ff    <= 1'b0;
      pd_ff        <= 1'b0;
      pkt_err_ff   <= 1'b0;
      overtemp_ff  <= 1'b0;
      tsd_ff       <= 1'b0;
      monitor_ff   <= '0;
      aux_dir_ff   <= 1'b0;
      aux_data_ff  <= 1'b0;
      rd_data_ff   <= '0;
      rd_valid_ff  <= 1'b0;
      calc_ff      <= 1'b0;
      calc_b_ff    <= 1'b0;
      calc_ch_ff   <= '0;
    end else begin
      input_a_ff   <= nxt_input_a;
      input_b_ff   <= nxt_input_b;
      gain_ff      <= nxt_gain;
      offset_ff    <= nxt_offset;
      cal_a_ff     <= nxt_cal_a;
      cal_b_ff     <= nxt_cal_b;
      grp_ofs_ff   <= nxt_grp_ofs;
      ab_select_ff <= nxt_ab_select;
      ab_ff        <= nxt_ab;
      tsd_en_ff    <= nxt_tsd_en;
      pd_ff        <= nxt_pd;
      pkt_err_ff   <= nxt_pkt_err;
      overtemp_ff  <= nxt_overtemp;
      tsd_ff       <= nxt_tsd;
      monitor_ff   <= nxt_monitor;
      aux_dir_ff   <= nxt_aux_dir;
      aux_data_ff  <= nxt_aux_data;
      rd_data_ff   <= nxt_rd_data;
      rd_valid_ff  <= nxt_rd_valid;
      calc_ff      <= nxt_calc;
      calc_b_ff    <= nxt_calc_b;
      calc_ch_ff   <= nxt_calc_ch;
    end
  end

  // Final converter registers follow their source while load is held low
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_dac
    logic [DATA_W-1:0] nxt_dac;
    always_comb begin
      nxt_dac = dac_ff[ch];
      if (!load_outputs_n) begin
        nxt_dac = ab_select_ff[ch / GRP_SZ][ch % GRP_SZ] ? cal_b_ff[ch] : cal_a_ff[ch];
      end
    end
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        dac_ff[ch] <= CAL_RST;
      end else begin
        dac_ff[ch] <= nxt_dac;
      end
    end
  end

  assign rd_data            = rd_data_ff;
  assign rd_valid           = rd_valid_ff;
  assign aux_pin_o          = aux_data_ff;
  assign aux_pin_oe         = aux_dir_ff;
  assign dac_code           = dac_ff;
  assign group_offset_level = grp_ofs_ff;
  assign power_down         = pd_ff;
  assign thermal_shutdown   = tsd_ff;
  assign monitor_on         = monitor_ff[MON_ENABLE];
  assign monitor_use_ext    = monitor_ff[MON_EXT];
  assign monitor_channel    = monitor_ff[CH_W-1:0];
  assign monitor_input_one  = monitor_ff[MON_INPUT_1];

endmodule : mdacr_bank
`default_nettype wire

// File: sim/mdacr_bank_asserts.sv
// Port-level assertions of the DAC register bank
`default_nettype none
module mdacr_bank_asserts
  import mdacr_pkg::*;
(
  // Clock and reset
  input wire logic                          core_clk,
  input wire logic                          rst,
  // Command port
  input wire mdacr_req_t                    req,
  input wire logic [15:0]                   rd_data,
  input wire logic                          rd_valid,
  // Pins and outputs
  input wire logic                          load_outputs_n,
  input wire logic                          over_temp,
  input wire logic                          pec_fail,
  input wire logic                          aux_pin_o,
  input wire logic                          aux_pin_oe,
  input wire logic [NUM_CH-1:0][DATA_W-1:0] dac_code,
  input wire logic [NUM_GRP-1:0][OFS_W-1:0] group_offset_level,
  input wire logic                          power_down,
  input wire logic                          thermal_shutdown,
  input wire logic                          monitor_on,
  input wire logic                          monitor_use_ext,
  input wire logic [CH_W-1:0]               monitor_channel,
  input wire logic                          monitor_input_one
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rd_answer; req.rd |=> rd_valid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  property p_pdown; req.wr && req.sel == SEL_CONTROL |=> power_down == $past(req.data[0]); endproperty
  a_pdown: assert property (p_pdown) else $error("power down bit not taken");
  property p_tsd; $rose(thermal_shutdown) |-> $past(over_temp, 2); endproperty
  a_tsd: assert property (p_tsd) else $error("shutdown without overtemperature");
  // The reset edge is excluded: the flag still held its cleared value then
  property p_ot; req.rd && req.sel == SEL_CONTROL && over_temp && $past(over_temp) && !$past(rst) |=> rd_data[4];
  endproperty
  a_ot: assert property (p_ot) else $error("overtemperature bit not read");
  property p_pec; pec_fail ##1 (req.rd && req.sel == SEL_CONTROL) |=> rd_data[3]; endproperty
  a_pec: assert property (p_pec) else $error("packet error flag not set");
  property p_mon; req.wr && req.sel == SEL_MONITOR |=> {monitor_on, monitor_use_ext, monitor_channel} ==
    $past(req.data[5:0]) && monitor_input_one == $past(req.data[0]); endproperty
  a_mon: assert property (p_mon) else $error("monitor outputs wrong");
  property p_grp; req.wr && req.sel == SEL_GRP_OFS |=> group_offset_level[$past(req.chan[0])] ==
    $past(req.data[13:0]); endproperty
  a_grp: assert property (p_grp) else $error("group offset not written");
  property p_dir; req.wr && req.sel == SEL_AUX_PIN |=> aux_pin_oe == $past(req.data[1]); endproperty
  a_dir: assert property (p_dir) else $error("pin direction wrong");
  property p_drv; req.wr && req.sel == SEL_AUX_PIN && req.data[1] |=> aux_pin_o == $past(req.data[0]); endproperty
  a_drv: assert property (p_drv) else $error("pin drive level wrong");
  property p_hold; load_outputs_n |=> $stable(dac_code); endproperty
  a_hold: assert property (p_hold) else $error("converter code moved without load");
endmodule : mdacr_bank_asserts
bind mdacr_bank mdacr_bank_asserts i_asserts (.core_clk(core_clk), .rst(rst), .req(req), .rd_data(rd_data),
  .rd_valid(rd_valid), .load_outputs_n(load_outputs_n), .over_temp(over_temp), .pec_fail(pec_fail),
  .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe), .dac_code(dac_code), .group_offset_level(group_offset_level),
  .power_down(power_down), .thermal_shutdown(thermal_shutdown), .monitor_on(monitor_on),
  .monitor_use_ext(monitor_use_ext), .monitor_channel(monitor_channel), .monitor_input_one(monitor_input_one));
`default_nettype wire

// File: sim/mdacr_host.sv
// Host model issuing register accesses on the command port
`default_nettype none
module mdacr_host
  import mdacr_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Command and answer
  output var  mdacr_req_t  req,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // Called at a falling edge; the idle cycle after each access keeps req from being driven twice at once
  task automatic access(input logic w, input mdacr_sel_t s, input logic [3:0] c, input logic [15:0] d,
                        output logic [15:0] q);
    req <= '{wr: w, rd: !w, sel: s, chan: c, data: d};
    @(negedge core_clk);
    q = rd_valid ? rd_data : 'x;
    req <= '0;
    @(negedge core_clk);
  endtask : access
endmodule : mdacr_host
`default_nettype wire

// File: sim/mdacr_bank_tb.sv
// Self-checking bench of the DAC register bank against a behavioural model
`default_nettype none
module mdacr_bank_tb
  import mdacr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          core_clk, rst, code_format_select, load_outputs_n, over_temp, pec_fail;
  logic                          aux_pin_i, pin_ext, aux_pin_o, aux_pin_oe, power_down, thermal_shutdown;
  logic                          rd_valid, monitor_on, monitor_use_ext, monitor_input_one;
  logic [CH_W-1:0]               monitor_channel;
  logic [15:0]                   rd_data;
  logic [NUM_CH-1:0][DATA_W-1:0] dac_code;
  logic [NUM_GRP-1:0][OFS_W-1:0] group_offset_level;
  mdacr_req_t                    req;
  int                            in_ab[2][16], gain[16], ofs[16], cal_ab[2][16];
  int                            err_count, tests_run, seed, ch, ab, d;
  // Released pin follows the external level pin_ext
  assign aux_pin_i = aux_pin_oe ? aux_pin_o : pin_ext;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  mdacr_host i_host (.core_clk(core_clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));
  mdacr_bank i_dut (.core_clk(core_clk), .rst(rst), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .code_format_select(code_format_select), .load_outputs_n(load_outputs_n), .over_temp(over_temp),
    .pec_fail(pec_fail), .aux_pin_i(aux_pin_i), .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe),
    .dac_code(dac_code), .group_offset_level(group_offset_level), .power_down(power_down),
    .thermal_shutdown(thermal_shutdown), .monitor_on(monitor_on), .monitor_use_ext(monitor_use_ext),
    .monitor_channel(monitor_channel), .monitor_input_one(monitor_input_one));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input mdacr_sel_t s, input int c, input int v);
    logic [15:0] r;
    i_host.access(1'b1, s, c[3:0], v[15:0], r);
  endtask : wr
  task automatic rd(input mdacr_sel_t s, input int c, input logic [15:0] exp);
    logic [15:0] r;
    i_host.access(1'b0, s, c[3:0], 16'h0000, r);
    chk(r, exp);
  endtask : rd
  // Trimmed code, saturated to the converter range
  function automatic int cal(int x, int m, int c);
    longint r;
    r = ((longint'(x ^ (code_format_select ? 32'h8000 : 32'h0000)) * (m + 1)) >>> 16) + c - 32'h8000;
    return (r < 0) ? 0 : (r > 65535) ? 65535 : int'(r);
  endfunction : cal
  task automatic wrap_up;
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    #50us;
    err_count++;
    wrap_up();
  end
  initial begin
    seed = 55831;
    err_count = 0;
    tests_run = 0;
    rst = 1'b1;
    {code_format_select, over_temp, pec_fail, pin_ext} = 4'h0;
    load_outputs_n = 1'b1;
    foreach (gain[i]) begin
      gain[i] = 65535;
      ofs[i] = 32768;
      in_ab[0][i] = 32768;
      in_ab[1][i] = 32768;
    end
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    rd(SEL_CONTROL, 0, 16'h0000);
    rd(SEL_GAIN, 5, 16'hFFFF);
    rd(SEL_INPUT_B, 9, 16'h8000);
    rd(mdacr_sel_t'(4'hF), 0, 16'h0000);
    chk(dac_code[3], 16'h8000);
    for (int k = 0; k < 12; k++) begin
      ab = k % 2;
      ch = $random(seed) & 15;
      code_format_select = 1'($random(seed));
      wr(SEL_CONTROL, 0, ab << 2);
      gain[ch] = $random(seed) & 16'hFFFF;
      wr(SEL_GAIN, ch, gain[ch]);
      ofs[ch] = $random(seed) & 16'hFFFF;
      wr(SEL_OFFSET, ch, ofs[ch]);
      in_ab[ab][ch] = $random(seed) & 16'hFFFF;
      wr(SEL_INPUT, ch, in_ab[ab][ch]);
      cal_ab[ab][ch] = cal(in_ab[ab][ch], gain[ch], ofs[ch]);
      rd(ab ? SEL_INPUT_B : SEL_INPUT_A, ch, in_ab[ab][ch][15:0]);
      rd(SEL_INPUT, ch, in_ab[ab][ch][15:0]);
      rd(SEL_OFFSET, ch, ofs[ch][15:0]);
      wr(SEL_AB_SELECT, ch >> 3, ab ? 16'h00FF : 16'h0000);
      load_outputs_n = 1'b0;
      repeat (2) @(negedge core_clk);
      load_outputs_n = 1'b1;
      chk(dac_code[ch], cal_ab[ab][ch][15:0]);
      in_ab[ab][ch] = in_ab[ab][ch] ^ 16'h5555;
      wr(SEL_INPUT, ch, in_ab[ab][ch]);
      repeat (3) @(negedge core_clk);
      chk(dac_code[ch], cal_ab[ab][ch][15:0]);
      cal_ab[ab][ch] = cal(in_ab[ab][ch], gain[ch], ofs[ch]);
    end
    wr(SEL_CONTROL, 0, 16'hFFFF);
    rd(SEL_CONTROL, 0, 16'h0007);
    chk(16'(power_down), 16'h0001);
    over_temp = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(16'(thermal_shutdown), 16'h0001);
    rd(SEL_CONTROL, 0, 16'h0017);
    pec_fail = 1'b1;
    @(negedge core_clk);
    pec_fail = 1'b0;
    rd(SEL_CONTROL, 0, 16'h001F);
    rd(SEL_CONTROL, 0, 16'h0017);
    over_temp = 1'b0;
    wr(SEL_CONTROL, 0, 16'h0000);
    rd(SEL_CONTROL, 0, 16'h0000);
    d = $random(seed) & 16'h3FFF;
    wr(SEL_GRP_OFS, 0, d);
    wr(SEL_GRP_OFS, 1, 16'hFFFF);
    chk(16'(group_offset_level[0]), d[15:0]);
    rd(SEL_GRP_OFS, 1, 16'h3FFF);
    for (int k = 0; k < 4; k++) begin
      d = $random(seed) & 16'h003F;
      wr(SEL_MONITOR, 0, d);
      rd(SEL_MONITOR, 0, d[15:0]);
      chk({10'h000, monitor_on, monitor_use_ext, monitor_channel}, d[15:0]);
      chk(16'(monitor_input_one), 16'(d & 1));
    end
    wr(SEL_AUX_PIN, 0, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      pin_ext = 1'($random(seed));
      @(negedge core_clk);
      rd(SEL_AUX_PIN, 0, {15'h0000, pin_ext});
    end
    chk(16'(aux_pin_oe), 16'h0000);
    wr(SEL_AUX_PIN, 0, 16'h0003);
    chk({14'h0000, aux_pin_oe, aux_pin_o}, 16'h0003);
    rd(SEL_AUX_PIN, 0, 16'h0003);
    wr(SEL_AUX_PIN, 0, 16'h0002);
    chk({14'h0000, aux_pin_oe, aux_pin_o}, 16'h0002);
    wrap_up();
  end
endmodule : mdacr_bank_tb
`default_nettype wire
